// ---- design/dsps_consts.vh ----
// constants for the drive stop and power dip supervisor
`ifndef DSPS_CONSTS_VH
`define DSPS_CONSTS_VH
`define DSPS_CLK_MHZ 100
`define DSPS_TICK_US 1000
`define DSPS_MS_CYCLES (`DSPS_TICK_US * `DSPS_CLK_MHZ)
`define DSPS_ADR_CFG 8'h00
`define DSPS_ADR_HOLD 8'h04
`define DSPS_ADR_FLIM 8'h08
`define DSPS_ADR_CMD 8'h0c
`define DSPS_ADR_STAT 8'h10
`define DSPS_ADR_ISTAT 8'h14
`define DSPS_ADR_IMASK 8'h18
`define DSPS_CFG_SOS_LSB 0
`define DSPS_CFG_GR2_BIT 2
`define DSPS_CFG_UVM_LSB 4
`define DSPS_CFG_MAXSPD_LSB 8
`define DSPS_FLIM_REL_LSB 16
`define DSPS_CMD_RESTART_BIT 0
`define DSPS_SOS_RST 2'h0
`define DSPS_GR2_RST 1'h0
`define DSPS_UVM_RST 2'h0
`define DSPS_MAXSPD_RST 7'h32
`define DSPS_MAXSPD_MIN 7'h01
`define DSPS_MAXSPD_MAX 7'h64
`define DSPS_SPD_UNIT 7'h64
`define DSPS_HOLD_RST 10'h014
`define DSPS_HOLD_MIN 10'h014
`define DSPS_HOLD_MAX 10'h3e8
`define DSPS_DROP_RST 7'h32
`define DSPS_PCT_FULL 7'h64
`define DSPS_REL_RST 10'h064
`define DSPS_REL_MAX 10'h3e8
`define DSPS_DIP_SAT 10'h3ff
`define DSPS_SOS_DB_HOLD 2'h0
`define DSPS_SOS_DB_COAST 2'h1
`define DSPS_SOS_COAST 2'h2
`define DSPS_UVM_OFF 2'h0
`define DSPS_UVM_HOST 2'h1
`define DSPS_UVM_INT 2'h2
`define DSPS_MODE_FORCE 2'h2
`define DSPS_IRQ_W 5
`define DSPS_IRQ_DIP 0
`define DSPS_IRQ_OVS 1
`define DSPS_IRQ_UVW 2
`define DSPS_IRQ_STOP 3
`define DSPS_IRQ_CTRL 4
`endif

// ---- design/dsps_tick.v ----
// millisecond tick generator
`timescale 1ns/100ps
module dsps_tick #(
	parameter CYCLES = 100000
) (
	input wire clk_i,
	input wire rst_i,
	output reg tick_o
);
	reg [31:0] cnt;

	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 32'h0;
			tick_o <= 1'b0;
		end else if (cnt == CYCLES - 1) begin
			cnt <= 32'h0;
			tick_o <= 1'b1;
		end else begin
			cnt <= cnt + 32'h1;
			tick_o <= 1'b0;
		end
	end
endmodule

// ---- design/dsps_supervisor.v ----
// drive stop selection, power dip ride-through, overspeed and force limit logic
// Overview of operation
// RQ1: group-2 alarm default: zero-speed stop, then brake/coast
// RQ2: group-2 select 1: stop like group-1 alarm
// RQ3: force control ignores group-2 stop select
// RQ4: dips shorter than hold time keep running
// RQ5: long dip cuts power, restores on recovery
// RQ6: long dip clears servo ready output
// RQ7: control power loss ignores hold time
// RQ8: undervoltage alarm during dip ignores hold time
// RQ9: overspeed alarm above max speed setting
// RQ10: undervoltage mode: off, host, internal limit
// RQ11: host limits force until warning clears
// RQ12: internal clamp, then ramp over release time
// RQ13: dropout limit 0..100 percent, default 50
// RQ14: release time 0..1000 ms, default 100
// RQ15: user should set hold time to 1000
// RQ16: servo off cuts motor current at once
// RQ17: stop select: brake-hold, brake-coast, coast
// RQ18: stop, mode, speed settings latch at restart
`timescale 1ns/100ps
`include "dsps_consts.vh"
module dsps_supervisor #(
	parameter MS_CYCLES = `DSPS_MS_CYCLES
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire servo_on_in_i,
	input wire main_dip_i,
	input wire ctrl_power_lost_i,
	input wire uv_level_i,
	input wire undervoltage_alarm_i,
	input wire gr1_alarm_i,
	input wire second_alarm_group_i,
	input wire [1:0] ctrl_mode_i,
	input wire [15:0] motor_speed_i,
	input wire motor_stopped_i,
	output reg motor_power_o,
	output reg speed_ref_zero_o,
	output reg dynamic_brake_o,
	output reg servo_ready_out_o,
	output reg uv_warning_o,
	output reg overspeed_alarm_o,
	output reg [6:0] force_limit_o,
	output wire irq_o
);
	localparam ST_RUN = 4'h1;
	localparam ST_ZERO = 4'h2;
	localparam ST_BRAKE = 4'h4;
	localparam ST_STOP = 4'h8;
	localparam NPIN = 7;

	// pin synchronisers
	wire [NPIN-1:0] pin_raw;
	reg [NPIN-1:0] pin_m;
	reg [NPIN-1:0] pin_s;
	assign pin_raw = {servo_on_in_i, main_dip_i, ctrl_power_lost_i, uv_level_i,
		undervoltage_alarm_i, gr1_alarm_i, second_alarm_group_i};
	genvar g;
	generate
		for (g = 0; g < NPIN; g = g + 1) begin : sync
			always @(posedge clk_i) begin
				if (rst_i) begin
					pin_m[g] <= 1'b0;
					pin_s[g] <= 1'b0;
				end else begin
					pin_m[g] <= pin_raw[g];
					pin_s[g] <= pin_m[g];
				end
			end
		end
	endgenerate
	wire servo_on = pin_s[6];
	wire dip = pin_s[5];
	wire ctrl_lost = pin_s[4];
	wire uv_level = pin_s[3];
	wire uv_alarm = pin_s[2];
	wire gr1 = pin_s[1];
	wire gr2 = pin_s[0];

	wire tick;
	dsps_tick #(.CYCLES(MS_CYCLES)) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_o(tick)
	);

	// software settings and active copies
	reg [1:0] sos_sh;
	reg gr2_sh;
	reg [1:0] uvm_sh;
	reg [6:0] maxspd_sh;
	reg [1:0] sos;
	reg gr2_sel;
	reg [1:0] uvm;
	reg [6:0] maxspd;
	reg [9:0] hold;
	reg [6:0] drop;
	reg [9:0] rel;
	reg [`DSPS_IRQ_W-1:0] istat;
	reg [`DSPS_IRQ_W-1:0] imask;
	reg [3:0] state;
	reg [3:0] next_state;
	reg [9:0] dip_cnt;
	reg [16:0] acc;
	reg ovs;
	reg dip_long_q;
	reg uvw_q;
	reg ctrl_q;

	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] d;
		input [3:0] s;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1)
				wmerge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	wire [31:0] rd_cfg = {17'h0, maxspd_sh, 2'h0, uvm_sh, 1'b0, gr2_sh, sos_sh};
	wire [31:0] rd_hold = {22'h0, hold};
	wire [31:0] rd_flim = {6'h0, rel, 9'h0, drop};
	wire [31:0] wr_cfg = wmerge(rd_cfg, wb_dat_i, wb_sel_i);
	wire [31:0] wr_hold = wmerge(rd_hold, wb_dat_i, wb_sel_i);
	wire [31:0] wr_flim = wmerge(rd_flim, wb_dat_i, wb_sel_i);
	wire [31:0] wr_any = wmerge(32'h0, wb_dat_i, wb_sel_i);
	wire [6:0] wr_spd = wr_cfg[`DSPS_CFG_MAXSPD_LSB +: 7];
	wire [9:0] wr_hv = wr_hold[9:0];
	wire [6:0] wr_dv = wr_flim[6:0];
	wire [9:0] wr_rv = wr_flim[`DSPS_FLIM_REL_LSB +: 10];

	wire req = wb_cyc_i & wb_stb_i;
	wire wr = req & wb_we_i & wb_ack_o;
	wire wr_cfg_en = wr & (wb_adr_i == `DSPS_ADR_CFG);
	wire wr_hold_en = wr & (wb_adr_i == `DSPS_ADR_HOLD);
	wire wr_flim_en = wr & (wb_adr_i == `DSPS_ADR_FLIM);
	wire wr_ist_en = wr & (wb_adr_i == `DSPS_ADR_ISTAT);
	wire wr_imk_en = wr & (wb_adr_i == `DSPS_ADR_IMASK);
	wire restart = wr & (wb_adr_i == `DSPS_ADR_CMD) & wr_any[`DSPS_CMD_RESTART_BIT];

	// power dip timing
	wire dip_long = dip & (dip_cnt > hold); // RQ4
	wire force_mode = (ctrl_mode_i == `DSPS_MODE_FORCE);
	wire gr2_as_gr1 = gr2_sel | force_mode; // RQ2 RQ3
	wire [13:0] spd_lim = {7'h0, maxspd} * {7'h0, `DSPS_SPD_UNIT};
	wire ovs_now = motor_speed_i > {2'h0, spd_lim}; // RQ9
	wire hard_stop = ~servo_on | gr1 | ovs | ctrl_lost | uv_alarm | dip_long
		| (gr2 & gr2_as_gr1); // RQ16 RQ7 RQ8 RQ5
	wire zero_stop = gr2 & ~gr2_as_gr1; // RQ1
	wire uv_warn = (uvm != `DSPS_UVM_OFF) & uv_level; // RQ10
	wire [6:0] drop_gap = `DSPS_PCT_FULL - drop;
	wire [`DSPS_IRQ_W-1:0] ev;
	assign ev[`DSPS_IRQ_DIP] = dip_long & ~dip_long_q;
	assign ev[`DSPS_IRQ_OVS] = ovs_now & ~ovs;
	assign ev[`DSPS_IRQ_UVW] = uv_warn & ~uvw_q;
	assign ev[`DSPS_IRQ_STOP] = (state[0] | state[1]) & next_state[2];
	assign ev[`DSPS_IRQ_CTRL] = ctrl_lost & ~ctrl_q;
	assign irq_o = |(istat & imask);

	// wishbone slave, one wait state
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			if (req & ~wb_ack_o) begin
				case (wb_adr_i)
					`DSPS_ADR_CFG: wb_dat_o <= rd_cfg;
					`DSPS_ADR_HOLD: wb_dat_o <= rd_hold;
					`DSPS_ADR_FLIM: wb_dat_o <= rd_flim;
					`DSPS_ADR_STAT: wb_dat_o <= {12'h0, force_limit_o, 1'b0, state,
						uv_warning_o, servo_ready_out_o, ovs, dip_long, motor_power_o,
						dynamic_brake_o, speed_ref_zero_o, dip};
					`DSPS_ADR_ISTAT: wb_dat_o <= {27'h0, istat};
					`DSPS_ADR_IMASK: wb_dat_o <= {27'h0, imask};
					default: wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	// settings registers
	always @(posedge clk_i) begin
		if (rst_i) begin
			sos_sh <= `DSPS_SOS_RST;
			gr2_sh <= `DSPS_GR2_RST;
			uvm_sh <= `DSPS_UVM_RST;
			maxspd_sh <= `DSPS_MAXSPD_RST;
			sos <= `DSPS_SOS_RST;
			gr2_sel <= `DSPS_GR2_RST;
			uvm <= `DSPS_UVM_RST;
			maxspd <= `DSPS_MAXSPD_RST;
			hold <= `DSPS_HOLD_RST;
			drop <= `DSPS_DROP_RST;
			rel <= `DSPS_REL_RST;
			imask <= {`DSPS_IRQ_W{1'b0}};
		end else begin
			if (wr_cfg_en) begin
				sos_sh <= (wr_cfg[1:0] > `DSPS_SOS_COAST) ? `DSPS_SOS_COAST : wr_cfg[1:0];
				gr2_sh <= wr_cfg[`DSPS_CFG_GR2_BIT];
				uvm_sh <= (wr_cfg[5:4] > `DSPS_UVM_INT) ? `DSPS_UVM_INT : wr_cfg[5:4];
				maxspd_sh <= (wr_spd < `DSPS_MAXSPD_MIN) ? `DSPS_MAXSPD_MIN :
					(wr_spd > `DSPS_MAXSPD_MAX) ? `DSPS_MAXSPD_MAX : wr_spd;
			end
			if (restart) begin
				sos <= sos_sh; // RQ18 RQ17
				gr2_sel <= gr2_sh; // RQ18
				uvm <= uvm_sh; // RQ18
				maxspd <= maxspd_sh; // RQ18
			end
			if (wr_hold_en)
				hold <= (wr_hv < `DSPS_HOLD_MIN) ? `DSPS_HOLD_MIN :
					(wr_hv > `DSPS_HOLD_MAX) ? `DSPS_HOLD_MAX : wr_hv; // RQ4
			if (wr_flim_en) begin
				drop <= (wr_dv > `DSPS_PCT_FULL) ? `DSPS_PCT_FULL : wr_dv; // RQ13
				rel <= (wr_rv > `DSPS_REL_MAX) ? `DSPS_REL_MAX : wr_rv; // RQ14
			end
			if (wr_imk_en)
				imask <= wr_any[`DSPS_IRQ_W-1:0];
		end
	end

	// interrupt status, a new event wins over the clear
	always @(posedge clk_i) begin
		if (rst_i) begin
			istat <= {`DSPS_IRQ_W{1'b0}};
			dip_long_q <= 1'b0;
			uvw_q <= 1'b0;
			ctrl_q <= 1'b0;
		end else begin
			istat <= (istat & ~(wr_ist_en ? wr_any[`DSPS_IRQ_W-1:0] :
				{`DSPS_IRQ_W{1'b0}})) | ev;
			dip_long_q <= dip_long;
			uvw_q <= uv_warn;
			ctrl_q <= ctrl_lost;
		end
	end

	// dip timer and overspeed latch
	always @(posedge clk_i) begin
		if (rst_i) begin
			dip_cnt <= 10'h0;
			ovs <= 1'b0;
		end else begin
			if (~dip)
				dip_cnt <= 10'h0;
			else if (tick && dip_cnt != `DSPS_DIP_SAT)
				dip_cnt <= dip_cnt + 10'h1;
			if (ovs_now)
				ovs <= 1'b1; // RQ9
			else if (restart)
				ovs <= 1'b0;
		end
	end

	// stop sequencer
	always @* begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (hard_stop)
					next_state = ST_BRAKE; // RQ16 RQ2
				else if (zero_stop)
					next_state = ST_ZERO; // RQ1
			end
			ST_ZERO: begin
				if (hard_stop)
					next_state = ST_BRAKE;
				else if (motor_stopped_i)
					next_state = ST_STOP; // RQ1
			end
			ST_BRAKE: begin
				if (motor_stopped_i)
					next_state = ST_STOP;
			end
			ST_STOP: begin
				if (~hard_stop & ~zero_stop)
					next_state = ST_RUN; // RQ5
			end
			default: next_state = ST_STOP;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_STOP;
			motor_power_o <= 1'b0;
			speed_ref_zero_o <= 1'b0;
			dynamic_brake_o <= 1'b0;
			servo_ready_out_o <= 1'b0;
			overspeed_alarm_o <= 1'b0;
		end else begin
			state <= next_state;
			motor_power_o <= next_state[0] | next_state[1]; // RQ5 RQ16
			speed_ref_zero_o <= next_state[1]; // RQ1
			dynamic_brake_o <= (next_state[2] & ((sos != `DSPS_SOS_COAST) | ctrl_lost
				| dip_long)) | (next_state[3] & (sos == `DSPS_SOS_DB_HOLD)); // RQ17 RQ7
			servo_ready_out_o <= ~dip_long & ~ctrl_lost & ~uv_alarm & ~gr1
				& ~gr2 & ~ovs; // RQ6
			overspeed_alarm_o <= (ovs & ~restart) | ovs_now; // RQ9 RQ18
		end
	end

	// undervoltage force limit and release ramp
	always @(posedge clk_i) begin
		if (rst_i) begin
			uv_warning_o <= 1'b0;
			force_limit_o <= `DSPS_PCT_FULL;
			acc <= 17'h0;
		end else begin
			uv_warning_o <= uv_warn; // RQ10 RQ11
			if (uvm != `DSPS_UVM_INT) begin
				force_limit_o <= `DSPS_PCT_FULL;
				acc <= 17'h0;
			end else if (uv_warn) begin
				force_limit_o <= drop; // RQ12
				acc <= 17'h0;
			end else if (force_limit_o < `DSPS_PCT_FULL) begin
				if (rel == 10'h0)
					force_limit_o <= `DSPS_PCT_FULL;
				else if (tick)
					acc <= acc + {10'h0, drop_gap}; // RQ12
				else if (acc >= {7'h0, rel}) begin
					force_limit_o <= force_limit_o + 7'h1;
					acc <= acc - {7'h0, rel};
				end
			end else
				acc <= 17'h0;
		end
	end
endmodule

// ---- testbench/dsps_host_model.sv ----
// host controller model: servo-on command and host-side force limit
`timescale 1ns/100ps
module dsps_host_model (
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic uv_warning_i,
	output logic servo_on_o = 1'h0,
	output logic [6:0] host_limit_o = 7'h64
);
	always @(posedge clk_i) begin
		servo_on_o <= run_i;
		host_limit_o <= uv_warning_i ? 7'h32 : 7'h64;
	end
endmodule

// ---- testbench/dsps_monitor.sv ----
// concurrent checks on the supervisor ports
`timescale 1ns/100ps
module dsps_monitor (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire servo_on_in_i,
	input wire ctrl_power_lost_i,
	input wire undervoltage_alarm_i,
	input wire second_alarm_group_i,
	input wire [1:0] ctrl_mode_i,
	input wire motor_power_o,
	input wire speed_ref_zero_o,
	input wire uv_warning_o,
	input wire overspeed_alarm_o,
	input wire [6:0] force_limit_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_servo_off_cut: assert property ($fell(servo_on_in_i) |-> ##[1:3] !motor_power_o)
		else $error("power stayed on after servo off");
	chk_ctrl_lost_off: assert property ($rose(ctrl_power_lost_i) |-> ##[1:3] !motor_power_o)
		else $error("power stayed on after control loss");
	chk_uv_alarm_off: assert property ($rose(undervoltage_alarm_i) |-> ##[1:3] !motor_power_o)
		else $error("power stayed on after undervoltage alarm");
	chk_force_mode_gr2: assert property (($rose(second_alarm_group_i) && ctrl_mode_i == 2'h2)
		##1 (ctrl_mode_i == 2'h2) [*2] |=> !motor_power_o) else $error("force mode group 2 no stop");
	chk_zero_keeps_power: assert property (speed_ref_zero_o |-> motor_power_o)
		else $error("zero speed stop without power");
	chk_overspeed_latch: assert property (overspeed_alarm_o && !(wb_cyc_i && wb_stb_i && wb_we_i
		&& wb_adr_i == 8'h0c) |=> overspeed_alarm_o) else $error("overspeed latch lost");
	chk_limit_range: assert property (force_limit_o <= 7'h64)
		else $error("force limit above full");
	chk_ramp_step: assert property (!uv_warning_o && force_limit_o > $past(force_limit_o) |->
		force_limit_o == $past(force_limit_o) + 7'h1 || force_limit_o == 7'h64)
		else $error("force limit ramp step wrong");
endmodule
bind dsps_supervisor dsps_monitor mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.servo_on_in_i, .ctrl_power_lost_i, .undervoltage_alarm_i, .second_alarm_group_i, .ctrl_mode_i,
	.motor_power_o, .speed_ref_zero_o, .uv_warning_o, .overspeed_alarm_o, .force_limit_o);

// ---- testbench/testbench.sv ----
// self-checking bench for the supervisor
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
	$display("mismatch %0t %h %h", $time, a, b); end end
`define WT(c) for (k = 0; k < 3000 && !(c); k++) @(posedge clk_i); \
	if (!(c)) fails++;
module testbench;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} dsps_row_t;
	logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	logic [7:0] wb_adr_i = 8'h0;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, rd, wb_dat_o;
	logic wb_ack_o, motor_power_o, speed_ref_zero_o, dynamic_brake_o, servo_ready_out_o;
	logic uv_warning_o, overspeed_alarm_o, irq_o, run = 1'h0, servo_on_in_i, main_dip_i = 1'h0;
	logic ctrl_power_lost_i = 1'h0, uv_level_i = 1'h0, undervoltage_alarm_i = 1'h0;
	logic gr1_alarm_i = 1'h0, second_alarm_group_i = 1'h0, motor_stopped_i = 1'h1;
	logic [1:0] ctrl_mode_i = 2'h0;
	logic [15:0] motor_speed_i = 16'h0;
	logic [6:0] force_limit_o, host_limit;
	int fails = 0, n_compared = 0, i, k;
	dsps_row_t rows [10] = '{'{1'h0, 8'h00, 32'h0, 32'h3200}, '{1'h0, 8'h04, 32'h0, 32'h14},
		'{1'h0, 8'h08, 32'h0, 32'h640032}, '{1'h0, 8'h20, 32'h0, 32'h0},
		'{1'h0, 8'h10, 32'h0, 32'hc8844},
		'{1'h1, 8'h04, 32'h5, 32'h14}, '{1'h1, 8'h04, 32'h3ff, 32'h3e8},
		'{1'h1, 8'h08, 32'h7ff0065, 32'h3e80064}, '{1'h1, 8'h04, 32'h14, 32'h14},
		'{1'h1, 8'h08, 32'h640032, 32'h640032}};
	dsps_supervisor #(.MS_CYCLES(20)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .servo_on_in_i, .main_dip_i,
		.ctrl_power_lost_i, .uv_level_i, .undervoltage_alarm_i, .gr1_alarm_i,
		.second_alarm_group_i, .ctrl_mode_i, .motor_speed_i, .motor_stopped_i, .motor_power_o,
		.speed_ref_zero_o, .dynamic_brake_o, .servo_ready_out_o, .uv_warning_o,
		.overspeed_alarm_o, .force_limit_o, .irq_o);
	dsps_host_model host (.clk_i, .run_i(run), .uv_warning_i(uv_warning_o),
		.servo_on_o(servo_on_in_i), .host_limit_o(host_limit));
	task automatic tk(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task end_of_test;
		if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial forever #5 clk_i = ~clk_i;
	initial begin
		#200000;
		fails++;
		end_of_test;
	end
	initial begin
		tk(2);
		rst_i <= 1'h0;
		tk(1);
		`CHK({motor_power_o, force_limit_o}, 8'h64)
		for (i = 0; i < 10; i++) begin
			if (rows[i].w) wb(1'h1, rows[i].a, rows[i].d);
			wb(1'h0, rows[i].a, 32'h0);
			`CHK(rd, rows[i].e)
		end
		run <= 1'h1;
		`WT(motor_power_o === 1'h1)
		main_dip_i <= 1'h1;
		tk(200);
		main_dip_i <= 1'h0;
		tk(5);
		`CHK({motor_power_o, servo_ready_out_o}, 2'h3)
		main_dip_i <= 1'h1;
		tk(600);
		`CHK({motor_power_o, servo_ready_out_o}, 2'h0)
		main_dip_i <= 1'h0;
		`WT(motor_power_o === 1'h1)
		`CHK({motor_power_o, irq_o}, 2'h2)
		wb(1'h1, 8'h18, 32'h1);
		`CHK(irq_o, 1'h1)
		wb(1'h1, 8'h14, 32'h1);
		`CHK(irq_o, 1'h0)
		for (i = 0; i < 4; i++) begin
			`WT(motor_power_o === 1'h1)
			{run, gr1_alarm_i, ctrl_power_lost_i, undervoltage_alarm_i} <= 4'h8 ^ (4'h8 >> i);
			tk(6);
			`CHK(motor_power_o, 1'h0)
			{run, gr1_alarm_i, ctrl_power_lost_i, undervoltage_alarm_i} <= 4'h8;
		end
		`WT(motor_power_o === 1'h1)
		motor_speed_i <= 16'h1388;
		tk(8);
		`CHK(overspeed_alarm_o, 1'h0)
		motor_speed_i <= 16'h1389;
		tk(8);
		`CHK({overspeed_alarm_o, motor_power_o}, 2'h2)
		motor_speed_i <= 16'h0;
		tk(8);
		`CHK(overspeed_alarm_o, 1'h1)
		wb(1'h1, 8'h00, 32'h3200);
		wb(1'h1, 8'h0c, 32'h1);
		`CHK(overspeed_alarm_o, 1'h0)
		wb(1'h1, 8'h00, 32'h3220);
		uv_level_i <= 1'h1;
		tk(8);
		`CHK({uv_warning_o, force_limit_o}, 8'h64)
		wb(1'h1, 8'h08, 32'ha001e);
		wb(1'h1, 8'h00, 32'h3220);
		wb(1'h1, 8'h0c, 32'h1);
		tk(8);
		`CHK({uv_warning_o, force_limit_o}, 8'h9e)
		uv_level_i <= 1'h0;
		tk(100);
		`CHK(force_limit_o < 7'h64, 1'h1)
		`WT(force_limit_o === 7'h64)
		`CHK(force_limit_o, 7'h64)
		wb(1'h1, 8'h00, 32'h3210);
		wb(1'h1, 8'h0c, 32'h1);
		uv_level_i <= 1'h1;
		tk(8);
		`CHK({uv_warning_o, force_limit_o, host_limit}, 15'h7232)
		uv_level_i <= 1'h0;
		tk(8);
		`CHK(host_limit, 7'h64)
		wb(1'h1, 8'h00, 32'h3200);
		wb(1'h1, 8'h0c, 32'h1);
		`WT(motor_power_o === 1'h1)
		motor_stopped_i <= 1'h0;
		second_alarm_group_i <= 1'h1;
		tk(5);
		`CHK({speed_ref_zero_o, motor_power_o}, 2'h3)
		motor_stopped_i <= 1'h1;
		tk(5);
		`CHK({speed_ref_zero_o, motor_power_o, dynamic_brake_o}, 3'h1)
		second_alarm_group_i <= 1'h0;
		ctrl_mode_i <= 2'h2;
		`WT(motor_power_o === 1'h1)
		second_alarm_group_i <= 1'h1;
		tk(5);
		`CHK({speed_ref_zero_o, motor_power_o}, 2'h0)
		second_alarm_group_i <= 1'h0;
		ctrl_mode_i <= 2'h0;
		wb(1'h1, 8'h00, 32'h3206);
		wb(1'h1, 8'h0c, 32'h1);
		`WT(motor_power_o === 1'h1)
		second_alarm_group_i <= 1'h1;
		tk(5);
		`CHK({speed_ref_zero_o, motor_power_o, dynamic_brake_o}, 3'h0)
		second_alarm_group_i <= 1'h0;
		tk(5);
		end_of_test;
	end
endmodule
